//--- src/felc_defs.vh
// Constants for the flash erase and lock controller: offsets, fields, resets and timing counts.
// Assumes a 50 MHz system clock and a byte-wide flash array of 1280 bytes.
`ifndef FELC_DEFS_VH
`define FELC_DEFS_VH
// Register indices on the plain register port.
`define FELC_OFS_CTRL     2'h0
`define FELC_OFS_CLKCFG   2'h1
`define FELC_OFS_STAT     2'h2
// Password carried in the upper byte of every control write.
`define FELC_PASSWORD     8'hA5
// Control register fields.
`define FELC_B_ERASE      1
`define FELC_B_MASS       2
`define FELC_B_WRITE      6
`define FELC_B_BLOCK      7
// Status register fields.
`define FELC_B_BUSY       0
`define FELC_B_ACCV       2
`define FELC_B_SEGA_LOCK  6
`define FELC_B_FAIL       7
// Clock configuration fields and reset value.
`define FELC_CLKCFG_RST   8'h00
`define FELC_SRC_AUX      2'h0
`define FELC_SRC_MAIN     2'h1
// Flash map: main at 0x000-0x3FF, information at 0x400-0x4FF.
`define FELC_INFO_BASE    11'h400
`define FELC_FLASH_TOP    11'h4FF
`define FELC_SEGA_TOP     11'h43F
`define FELC_INFO_SEG     11'h040
`define FELC_MAIN_SEG     11'h200
`define FELC_ERASED       8'hFF
// Timing generator ticks per operation; clock-loss limit in system cycles.
`define FELC_ERASE_TICKS  5000
`define FELC_PROG_TICKS   30
`define FELC_FAIL_CYCLES  1024
`endif

//--- src/felc_top.v
// Flash erase and lock controller: control registers, timing generator, erase walker and program path.
// Assumes the CPU uses the plain register port and the byte flash port on the same 50 MHz clock.
//
// How it works
// R1 - Idle means read mode, generator stopped
// R2 - Four 64-byte info, two 512-byte main segments
// R3 - Lock set blocks segment A, protects info
// R4 - Lock clear treats segment A normally
// R5 - Writing one toggles lock, zero ignored
// R6 - Erase sets ones, program only clears bits
// R7 - Mass and erase bits pick erase mode
// R8 - Dummy write in region starts erase
// R9 - Busy rises at launch, holds throughout
// R10 - Completion clears busy, mass and erase bits
// R11 - Dummy write outside region is ignored
// R12 - Launch from flash stalls the CPU
// R13 - Generator clock selected, then divided
// R14 - Software keeps generator between 257-476 kHz
// R15 - Lost timing clock aborts, sets fail
// R16 - Selected clock held on while busy
// R17 - Software avoids flash during operations
// R18 - Erase duration fixed, independent of size
// R19 - Flash access while busy sets violation
// R20 - Control writes need the password byte
//
// Added by the designer: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "felc_defs.vh"

module felc_top
#(
    parameter integer ERASE_TICKS = `FELC_ERASE_TICKS  // Generator ticks per erase.
)
(
    input  wire        CLK,
    input  wire        RST_N,
    input  wire [1:0]  ADDR,
    input  wire [15:0] WDATA,
    input  wire        WR,
    input  wire        RD,
    output reg  [15:0] RDATA,
    input  wire [10:0] MEM_ADDR,
    input  wire [7:0]  MEM_WDATA,
    input  wire        MEM_WR,
    input  wire        MEM_RD,
    input  wire        MEM_FROM_FLASH,
    output reg  [7:0]  MEM_RDATA,
    output reg         CPU_STALL,
    input  wire        AUX_CLOCK,
    input  wire        SUB_MAIN_CLOCK,
    input  wire        MAIN_CLOCK,
    output reg  [2:0]  CLOCK_KEEP_ON
);

    ////////////////////////////////////////////////////////////////////////
    // States, storage and functions.

    localparam [2:0] ST_IDLE  = 3'b001;  // Read mode.
    localparam [2:0] ST_ERASE = 3'b010;  // Erase cycle.
    localparam [2:0] ST_PROG  = 3'b100;  // Byte program.

    reg [7:0]  flash [0:1279];           // Flash array, one byte per address.
    reg [2:0]  state;                    // Controller state.
    reg        erase_select;             // Erase mode bit.
    reg        mass_erase_select;        // Mass erase mode bit.
    reg        write_select;             // Write mode bit.
    reg        block_write_select;       // Block write mode bit, handled as byte write.
    reg [7:0]  clkcfg;                   // Source select and divider.
    reg        info_seg_a_lock;          // Segment A lock, set at reset.
    reg        access_violation_flag;    // Flash touched while busy.
    reg        fail_flag;                // Operation aborted on clock loss.
    reg [10:0] walk_addr;                // Next byte the eraser clears.
    reg [10:0] walk_end;                 // Last byte of the erase range.
    reg        walking;                  // Eraser still clearing bytes.
    reg [12:0] tick_cnt;                 // Generator ticks in this operation.
    reg [5:0]  div_cnt;                  // Divider position.
    reg [10:0] loss_cnt;                 // Cycles since the last source edge.
    reg [10:0] prog_addr;                // Byte being programmed.
    reg [7:0]  prog_data;                // Data being programmed.
    reg [2:0]  sync1;                    // First synchroniser stage.
    reg [2:0]  sync2;                    // Second synchroniser stage.
    reg [2:0]  sync3;                    // Edge history, read after sync2.

    // True for an address inside the fitted flash.
    function in_flash;
        input [10:0] a;
        begin
            in_flash = (a <= `FELC_FLASH_TOP);
        end
    endfunction

    // True for an address inside segment A.
    function in_sega;
        input [10:0] a;
        begin
            in_sega = (a >= `FELC_INFO_BASE) && (a <= `FELC_SEGA_TOP);
        end
    endfunction

    // First byte of the segment holding an address.
    function [10:0] seg_base;
        input [10:0] a;
        begin
            if (a >= `FELC_INFO_BASE)
                seg_base = {a[10:6], 6'h00};    // see R2
            else
                seg_base = {a[10:9], 9'h000};   // see R2
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Timing generator clock: synchronise the three sources, pick one, divide it.

    wire [1:0] src_sel = clkcfg[7:6];
    wire [5:0] divider = clkcfg[5:0];
    reg        src_edge;                 // Rising edge of the selected source.
    reg        src_is_aux;
    reg        src_is_main;

    // Source select; both upper codes pick the sub-main clock.
    always @*
    begin
        src_is_aux  = (src_sel == `FELC_SRC_AUX);
        src_is_main = (src_sel == `FELC_SRC_MAIN);
        if (src_is_aux)
            src_edge = sync2[0] & ~sync3[0];   // see R13
        else if (src_is_main)
            src_edge = sync2[2] & ~sync3[2];   // see R13
        else
            src_edge = sync2[1] & ~sync3[1];   // see R13
    end

    // Source pins come from foreign clocks, so they pass two flip-flops first.
    always @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            sync1 <= 3'h0;
            sync2 <= 3'h0;
            sync3 <= 3'h0;
        end
        else
        begin
            sync1 <= {MAIN_CLOCK, SUB_MAIN_CLOCK, AUX_CLOCK};
            sync2 <= sync1;
            sync3 <= sync2;
        end
    end

    // One generator tick every divider+1 source edges; stopped in read mode.
    wire ftg_tick = (state != ST_IDLE) && src_edge && (div_cnt == divider);  // see R13
    wire clk_lost = (state != ST_IDLE) && (loss_cnt == `FELC_FAIL_CYCLES - 1);

    ////////////////////////////////////////////////////////////////////////
    // Launch decode for a write on the flash port.

    wire       any_erase = erase_select | mass_erase_select;
    wire       mem_ok    = MEM_WR && in_flash(MEM_ADDR);
    wire       in_info   = (MEM_ADDR >= `FELC_INFO_BASE);
    reg        erase_go;                 // Dummy write starts an erase.
    reg        prog_go;                  // Write starts a program.
    reg [10:0] next_walk_addr;
    reg [10:0] next_walk_end;

    // Pick the erase range from the mode bits and the lock.
    always @*
    begin
        erase_go       = 1'b0;
        prog_go        = 1'b0;
        next_walk_addr = seg_base(MEM_ADDR);
        next_walk_end  = `FELC_FLASH_TOP;
        if (state == ST_IDLE && mem_ok && any_erase)
        begin
            if (!mass_erase_select)
            begin
                // Single segment; segment A only while unlocked.
                erase_go      = !(info_seg_a_lock && in_sega(MEM_ADDR));  // see R3, R4, R7
                next_walk_end = in_info ? seg_base(MEM_ADDR) + `FELC_INFO_SEG - 11'h001
                                        : seg_base(MEM_ADDR) + `FELC_MAIN_SEG - 11'h001;
            end
            else if (erase_select && !info_seg_a_lock)
            begin
                // All erase with lock clear covers main and information.
                erase_go       = 1'b1;                  // see R4, R7
                next_walk_addr = 11'h000;
            end
            else
            begin
                // Main only; a dummy write into information is outside it.
                erase_go       = !in_info;              // see R3, R7, R11
                next_walk_addr = 11'h000;
                next_walk_end  = `FELC_INFO_BASE - 11'h001;
            end
        end
        else if (state == ST_IDLE && mem_ok && (write_select || block_write_select))
        begin
            prog_go = !(info_seg_a_lock && in_sega(MEM_ADDR));  // see R3
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Control state machine, generator counters and the flash array.

    wire busy      = (state != ST_IDLE);
    wire erase_end = (state == ST_ERASE) && !walking && (tick_cnt >= ERASE_TICKS[12:0]);
    wire prog_end  = (state == ST_PROG) && (tick_cnt >= `FELC_PROG_TICKS);
    wire reg_wr    = WR && (WDATA[15:8] == `FELC_PASSWORD);  // see R20
    wire mem_touch = (MEM_WR || MEM_RD) && in_flash(MEM_ADDR);
    wire finish    = erase_end || prog_end || clk_lost;

    // Sequencer: idle until a valid launch, then count ticks to the fixed end.
    always @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            state     <= ST_IDLE;    // see R1
            tick_cnt  <= 13'h0000;
            div_cnt   <= 6'h00;
            loss_cnt  <= 11'h000;
            walking   <= 1'b0;
            walk_addr <= 11'h000;
            walk_end  <= 11'h000;
            prog_addr <= 11'h000;
            prog_data <= 8'h00;
            CPU_STALL <= 1'b0;
        end
        else if (state == ST_IDLE)
        begin
            // Generator held off in read mode.
            tick_cnt <= 13'h0000;    // see R1
            div_cnt  <= 6'h00;
            loss_cnt <= 11'h000;
            if (erase_go)
            begin
                state     <= ST_ERASE;  // see R8
                walking   <= 1'b1;
                walk_addr <= next_walk_addr;
                walk_end  <= next_walk_end;
                CPU_STALL <= MEM_FROM_FLASH;  // see R12
            end
            else if (prog_go)
            begin
                state     <= ST_PROG;
                prog_addr <= MEM_ADDR;
                prog_data <= MEM_WDATA;
                CPU_STALL <= MEM_FROM_FLASH;  // see R12
            end
        end
        else if (finish)
        begin
            // Normal end or abort on a lost clock.
            state     <= ST_IDLE;    // see R10, R15
            walking   <= 1'b0;
            CPU_STALL <= 1'b0;
        end
        else
        begin
            // Loss watchdog restarts on each source edge.
            loss_cnt <= src_edge ? 11'h000 : loss_cnt + 11'h001;
            if (src_edge)
                div_cnt <= (div_cnt == divider) ? 6'h00 : div_cnt + 6'h01;
            // The count is fixed, so erase time ignores how much flash is fitted.
            if (ftg_tick && tick_cnt != 13'h1FFF)
                tick_cnt <= tick_cnt + 13'h0001;  // see R18
            if (walking)
            begin
                walking   <= (walk_addr != walk_end);
                walk_addr <= walk_addr + 11'h001;
            end
        end
    end

    // The array has no reset; erase writes ones, program can only clear bits.
    always @(posedge CLK)
    begin
        if (state == ST_ERASE && walking && !clk_lost)
            flash[walk_addr] <= `FELC_ERASED;                     // see R6
        else if (prog_end && !clk_lost)
            flash[prog_addr] <= flash[prog_addr] & prog_data;     // see R6
    end

    ////////////////////////////////////////////////////////////////////////
    // Control registers: mode bits, clock setup, lock and flags.

    // Erase and mass erase bits clear themselves at the end of an erase; password-less writes change nothing.
    always @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            erase_select          <= 1'b0;
            mass_erase_select     <= 1'b0;
            write_select          <= 1'b0;
            block_write_select    <= 1'b0;
            clkcfg                <= `FELC_CLKCFG_RST;
            info_seg_a_lock       <= 1'b1;
            access_violation_flag <= 1'b0;
            fail_flag             <= 1'b0;
        end
        else
        begin
            if (state == ST_ERASE && finish)
            begin
                erase_select      <= 1'b0;  // see R10
                mass_erase_select <= 1'b0;  // see R10
            end
            else if (reg_wr && !busy && ADDR == `FELC_OFS_CTRL)
            begin
                erase_select       <= WDATA[`FELC_B_ERASE];   // see R20
                mass_erase_select  <= WDATA[`FELC_B_MASS];
                write_select       <= WDATA[`FELC_B_WRITE];
                block_write_select <= WDATA[`FELC_B_BLOCK];
            end
            // Clock setup is frozen while busy so the generator rate holds.
            if (reg_wr && !busy && ADDR == `FELC_OFS_CLKCFG)
                clkcfg <= WDATA[7:0];
            if (reg_wr && ADDR == `FELC_OFS_STAT && WDATA[`FELC_B_SEGA_LOCK])
                info_seg_a_lock <= ~info_seg_a_lock;  // see R5
            // Hardware set wins over a software clear in the same cycle.
            if (busy && mem_touch && !CPU_STALL)
                access_violation_flag <= 1'b1;  // see R19
            else if (reg_wr && ADDR == `FELC_OFS_STAT)
                access_violation_flag <= WDATA[`FELC_B_ACCV];
            if (clk_lost)
                fail_flag <= 1'b1;  // see R15
            else if (reg_wr && ADDR == `FELC_OFS_STAT)
                fail_flag <= WDATA[`FELC_B_FAIL];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read paths and clock hold request.

    // Register reads answer one cycle later; unmapped indices read zero.
    always @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
            RDATA <= 16'h0000;
        else if (RD && ADDR == `FELC_OFS_CTRL)
            RDATA <= {8'h00, block_write_select, write_select, 3'h0,
                      mass_erase_select, erase_select, 1'b0};
        else if (RD && ADDR == `FELC_OFS_CLKCFG)
            RDATA <= {8'h00, clkcfg};
        else if (RD && ADDR == `FELC_OFS_STAT)
            RDATA <= {8'h00, fail_flag, info_seg_a_lock, 3'h0,
                      access_violation_flag, 1'b0, busy};  // see R9
        else if (RD)
            RDATA <= 16'h0000;
    end

    // Flash reads act like ROM when idle; while busy they return all ones.
    always @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
            MEM_RDATA <= 8'h00;
        else if (MEM_RD && in_flash(MEM_ADDR) && !busy)
            MEM_RDATA <= flash[MEM_ADDR];  // see R1
        else if (MEM_RD)
            MEM_RDATA <= `FELC_ERASED;
    end

    // From the launch edge to the end the selected source is held on against low-power requests.
    always @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
            CLOCK_KEEP_ON <= 3'h0;
        else if ((busy && !finish) || erase_go || prog_go)
            CLOCK_KEEP_ON <= {src_is_main, ~src_is_aux & ~src_is_main, src_is_aux};  // see R16
        else
            CLOCK_KEEP_ON <= 3'h0;
    end

endmodule // felc_top

`default_nettype wire

//--- testbench/felc_clock_model.sv
// Model of the three source clocks that the controller may pick for its timing generator.
// Assumes the bench scales real rates down; the main clock can be stopped on request.
`timescale 1ns/1ps
`default_nettype none
module felc_clock_model
(
    input  wire logic stop_main,       // High holds the main clock still, as a failed oscillator.
    output var  logic aux_clock,       // Auxiliary clock, 2 us period.
    output var  logic sub_main_clock,  // Sub-main clock, 260 ns period.
    output var  logic main_clock       // Main clock, 140 ns period.
);
    // Sources run far slower than half the system clock so the synchroniser sees each edge.
    // The slow auxiliary rate keeps generator ticks dominant over a segment walk; a mass erase walk outlasts eight undivided ticks.
    initial
    begin
        aux_clock = 1'b0;
        forever #1000 aux_clock = ~aux_clock;
    end
    initial
    begin
        sub_main_clock = 1'b0;
        forever #130 sub_main_clock = ~sub_main_clock;
    end
    // A stopped main clock freezes at its level, which is what a dead oscillator shows.
    initial
    begin
        main_clock = 1'b0;
        forever #70 main_clock = stop_main ? main_clock : ~main_clock;
    end
endmodule // felc_clock_model
`default_nettype wire

//--- testbench/felc_sva.sv
// Checker for the flash erase and lock controller, watching only top-level ports.
// Assumes the single CLK domain with asynchronous active-low RST_N.
`timescale 1ns/1ps
`default_nettype none
module felc_sva
#(
    parameter integer ERASE_TICKS = 5000  // Generator ticks per erase, handed on by the bind.
)
(
    input wire logic        CLK,
    input wire logic        RST_N,
    input wire logic [1:0]  ADDR,
    input wire logic [15:0] WDATA,
    input wire logic        WR,
    input wire logic        RD,
    input wire logic [15:0] RDATA,
    input wire logic [10:0] MEM_ADDR,
    input wire logic [7:0]  MEM_WDATA,
    input wire logic        MEM_WR,
    input wire logic        MEM_RD,
    input wire logic        MEM_FROM_FLASH,
    input wire logic [7:0]  MEM_RDATA,
    input wire logic        CPU_STALL,
    input wire logic        AUX_CLOCK,
    input wire logic        SUB_MAIN_CLOCK,
    input wire logic        MAIN_CLOCK,
    input wire logic [2:0]  CLOCK_KEEP_ON
);
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RST_N);
    // The kept-on clock vector is nonzero exactly while an operation runs.
    wire logic busy = |CLOCK_KEEP_ON;
    ////////////////////////////////////////////////////////////////////////////////
    sequence s_flash_launch;
        MEM_WR && MEM_FROM_FLASH;
    endsequence
    // Every operation lasts at least eight generator ticks of two or more cycles each, or 1024 cycles when aborted on a lost clock.
    sequence s_busy_run;
        busy [*8];
    endsequence
    property p_stall_cause;
        $rose(CPU_STALL) |-> $past(MEM_WR) && $past(MEM_FROM_FLASH);
    endproperty
    property p_stall_busy;
        CPU_STALL |-> busy;
    endproperty
    property p_stall_end;
        $fell(busy) |-> !CPU_STALL;
    endproperty
    property p_busy_cause;
        $rose(busy) |-> $past(MEM_WR);
    endproperty
    property p_busy_min;
        $rose(busy) |-> s_busy_run;
    endproperty
    property p_keep_onehot;
        busy |-> $onehot(CLOCK_KEEP_ON);
    endproperty
    property p_keep_stable;
        busy && $past(busy) |-> $stable(CLOCK_KEEP_ON);
    endproperty
    property p_busy_read;
        MEM_RD && busy |=> MEM_RDATA == 8'hFF;
    endproperty
    property p_rdata_hold;
        !RD |=> $stable(RDATA);
    endproperty
    property p_unmapped;
        RD && ADDR == 2'h3 |=> RDATA == 16'h0000;
    endproperty
    ////////////////////////////////////////////////////////////////////////////////
    a_stall_cause: assert property (p_stall_cause) else $error("stall rose without a flash launch");
    a_stall_busy: assert property (p_stall_busy) else $error("stall while idle");
    a_stall_end: assert property (p_stall_end) else $error("stall outlived the operation");
    a_busy_cause: assert property (p_busy_cause) else $error("operation began without a flash write");
    a_busy_min: assert property (p_busy_min) else $error("operation ended too early");
    a_keep_onehot: assert property (p_keep_onehot) else $error("kept-on clock not one-hot");
    a_keep_stable: assert property (p_keep_stable) else $error("kept-on clock changed mid-run");
    a_busy_read: assert property (p_busy_read) else $error("array data leaked while busy");
    a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved without a read");
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    c_flash_launch: cover property (s_flash_launch ##1 CPU_STALL);
endmodule // felc_sva
bind felc_top felc_sva #(.ERASE_TICKS(ERASE_TICKS)) u_felc_sva
(
    .CLK(CLK), .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
    .MEM_ADDR(MEM_ADDR), .MEM_WDATA(MEM_WDATA), .MEM_WR(MEM_WR), .MEM_RD(MEM_RD),
    .MEM_FROM_FLASH(MEM_FROM_FLASH), .MEM_RDATA(MEM_RDATA), .CPU_STALL(CPU_STALL),
    .AUX_CLOCK(AUX_CLOCK), .SUB_MAIN_CLOCK(SUB_MAIN_CLOCK), .MAIN_CLOCK(MAIN_CLOCK),
    .CLOCK_KEEP_ON(CLOCK_KEEP_ON)
);
`default_nettype wire

//--- testbench/testbench.sv
// Self-checking bench for the flash erase and lock controller.
// Assumes the clock model on the source clock inputs and eight generator ticks per erase.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic        CLK;             // 50 MHz system clock.
    logic        RST_N;           // Active-low reset.
    logic [1:0]  ADDR;
    logic [15:0] WDATA;
    logic        WR;
    logic        RD;
    logic [10:0] MEM_ADDR;
    logic [7:0]  MEM_WDATA;
    logic        MEM_WR;
    logic        MEM_RD;
    logic        MEM_FROM_FLASH;
    logic        stop_main;       // Stops the main source clock.
    wire  [15:0] RDATA;
    wire  [7:0]  MEM_RDATA;
    wire         CPU_STALL;
    wire         AUX_CLOCK;
    wire         SUB_MAIN_CLOCK;
    wire         MAIN_CLOCK;
    wire  [2:0]  CLOCK_KEEP_ON;
    int          num_errors;
    int          samples_checked;
    int          dur;             // Cycles of the last operation.
    logic [15:0] rv;
    felc_top #(.ERASE_TICKS(8)) u_felc_top
    (
        .CLK(CLK), .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
        .MEM_ADDR(MEM_ADDR), .MEM_WDATA(MEM_WDATA), .MEM_WR(MEM_WR), .MEM_RD(MEM_RD),
        .MEM_FROM_FLASH(MEM_FROM_FLASH), .MEM_RDATA(MEM_RDATA), .CPU_STALL(CPU_STALL),
        .AUX_CLOCK(AUX_CLOCK), .SUB_MAIN_CLOCK(SUB_MAIN_CLOCK), .MAIN_CLOCK(MAIN_CLOCK),
        .CLOCK_KEEP_ON(CLOCK_KEEP_ON)
    );
    felc_clock_model u_felc_clock_model
    (
        .stop_main(stop_main), .aux_clock(AUX_CLOCK), .sub_main_clock(SUB_MAIN_CLOCK),
        .main_clock(MAIN_CLOCK)
    );
    initial
    begin
        CLK = 1'b0;
        forever #10 CLK = ~CLK;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic results();
        $display("Checks %0d, errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Register and flash cycles: one-cycle strobes launched right after an edge.
    task automatic reg_wr(input logic [1:0] a, input logic [15:0] d);
        ADDR <= a;
        WDATA <= d;
        WR <= 1'b1;
        @(posedge CLK);
        WR <= 1'b0;
        @(posedge CLK);
    endtask
    task automatic reg_rd(input logic [1:0] a, output logic [15:0] d);
        ADDR <= a;
        RD <= 1'b1;
        @(posedge CLK);
        RD <= 1'b0;
        @(posedge CLK);
        d = RDATA;
    endtask
    task automatic mem_wr(input logic [10:0] a, input logic [7:0] d, input logic ff);
        MEM_ADDR <= a;
        MEM_WDATA <= d;
        MEM_FROM_FLASH <= ff;
        MEM_WR <= 1'b1;
        @(posedge CLK);
        MEM_WR <= 1'b0;
    endtask
    // Reads one array byte and compares it; the data stand in the cycle after the strobe.
    task automatic expect_byte(input logic [10:0] a, input logic [7:0] e);
        MEM_ADDR <= a;
        MEM_RD <= 1'b1;
        @(posedge CLK);
        MEM_RD <= 1'b0;
        @(posedge CLK);
        check({8'h00, MEM_RDATA}, {8'h00, e});
    endtask
    // Polls the busy flag through the status register, never touching the array.
    task automatic wait_idle();
        logic [15:0] s;
        dur = 0;
        do
        begin
            reg_rd(2'h2, s);
            dur += 2;
        end
        while (s[0] !== 1'b0 && dur < 10000);
        if (dur >= 10000)
        begin
            num_errors++;
            results();
        end
    endtask
    task automatic prog(input logic [10:0] a, input logic [7:0] d);
        mem_wr(a, d, 1'b0);
        wait_idle();
    endtask
    // A dummy write under the given mode; keep is the expected kept-on clock, zero when ignored.
    task automatic erase(input logic [15:0] ctrl, input logic [10:0] a, input logic ff, input logic [2:0] keep);
        reg_wr(2'h0, ctrl);
        mem_wr(a, 8'h00, ff);
        @(posedge CLK);
        check({13'h0000, CLOCK_KEEP_ON}, {13'h0000, keep});
        check({15'h0000, CPU_STALL}, {15'h0000, ff & (|keep)});
        if (keep != 3'b000)
            wait_idle();
        reg_rd(2'h0, rv);
        check(rv, (keep != 3'b000) ? 16'h0000 : {8'h00, ctrl[7:0]});
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        {RST_N, ADDR, WDATA, WR, RD, MEM_ADDR, MEM_WDATA, MEM_WR, MEM_RD, MEM_FROM_FLASH, stop_main} = '0;
        num_errors = 0;
        samples_checked = 0;
        repeat (5) @(posedge CLK);
        RST_N <= 1'b1;
        @(posedge CLK);
        reg_rd(2'h2, rv); check(rv, 16'h0040);
        reg_rd(2'h1, rv); check(rv, 16'h0000);
        reg_rd(2'h3, rv); check(rv, 16'h0000);
        reg_wr(2'h0, 16'h5A06); reg_rd(2'h0, rv); check(rv, 16'h0000);
        reg_wr(2'h2, 16'hA540); reg_rd(2'h2, rv); check(rv, 16'h0000);
        reg_wr(2'h2, 16'hA500); reg_rd(2'h2, rv); check(rv, 16'h0000);
        erase(16'hA506, 11'h000, 1'b0, 3'b001);
        expect_byte(11'h000, 8'hFF); expect_byte(11'h3FF, 8'hFF);
        expect_byte(11'h400, 8'hFF); expect_byte(11'h4FF, 8'hFF);
        reg_wr(2'h0, 16'hA540);
        prog(11'h410, 8'h5A); prog(11'h410, 8'hF0); expect_byte(11'h410, 8'h50);
        prog(11'h400, 8'h3C); expect_byte(11'h400, 8'h3C);
        prog(11'h000, 8'h00); prog(11'h200, 8'h00);
        reg_wr(2'h2, 16'hA540);
        mem_wr(11'h401, 8'h00, 1'b0); reg_rd(2'h2, rv); check(rv, 16'h0040);
        expect_byte(11'h401, 8'hFF);
        erase(16'hA502, 11'h400, 1'b0, 3'b000);
        erase(16'hA502, 11'h500, 1'b0, 3'b000);
        erase(16'hA502, 11'h000, 1'b1, 3'b001);
        expect_byte(11'h000, 8'hFF); expect_byte(11'h200, 8'h00);
        erase(16'hA504, 11'h410, 1'b0, 3'b000);
        erase(16'hA504, 11'h200, 1'b0, 3'b001);
        expect_byte(11'h200, 8'hFF); expect_byte(11'h410, 8'h50);
        reg_wr(2'h0, 16'hA540); prog(11'h000, 8'h00);
        erase(16'hA506, 11'h410, 1'b0, 3'b000);
        erase(16'hA506, 11'h000, 1'b0, 3'b001);
        expect_byte(11'h000, 8'hFF); expect_byte(11'h400, 8'h3C);
        reg_wr(2'h1, 16'hA580); erase(16'hA502, 11'h000, 1'b0, 3'b010);
        reg_wr(2'h1, 16'hA540); erase(16'hA502, 11'h000, 1'b0, 3'b100);
        reg_wr(2'h1, 16'hA503); erase(16'hA502, 11'h000, 1'b0, 3'b001);
        check({15'h0000, dur >= 3000}, 16'h0001);
        // A dead main clock must abort the erase and raise the failure flag.
        reg_wr(2'h1, 16'hA540); stop_main <= 1'b1;
        erase(16'hA502, 11'h000, 1'b0, 3'b100);
        reg_rd(2'h2, rv); check(rv, 16'h00C0);
        stop_main <= 1'b0; reg_wr(2'h2, 16'hA500); reg_wr(2'h1, 16'hA500);
        // An array read during an erase started from RAM is a violation.
        reg_wr(2'h0, 16'hA502); mem_wr(11'h000, 8'h00, 1'b0);
        expect_byte(11'h000, 8'hFF); wait_idle();
        reg_rd(2'h2, rv); check(rv, 16'h0044);
        reg_wr(2'h2, 16'hA500); reg_rd(2'h2, rv); check(rv, 16'h0040);
        results();
    end
endmodule // testbench
`default_nettype wire
